/* logic/tosr_pkg.sv */
// What this block does
// - Crystal oscillator runs only while test word bit 15 is one; default zero.
// - Audio high-impedance bit 14 holds both audio outputs at mid-supply bias.
// - High-impedance applies only when powered down with interface supply present.
// - Status bit 15 flags a new RDS group ready; zero otherwise and at reset.
// - Status bit 14 sets when a seek or tune finishes; default zero.
// - Seek/tune-complete clears when host drops the seek or tune request.
// - Wrap mode zero: bit 13 sets when seek finds no qualifying channel.
// - Wrap mode one: bit 13 sets when seek reaches a band edge.
// - Seek-fail bit holds until host drops seek request, then clears.
// - Status bit 12 flags railed frequency control; audio softmuted while set.
// - Railed bit updates at seek/tune end and during normal reception.
// - Verbose mode only: bit 11 shows RDS decoder synchronized.
// - Verbose mode only: bits 10:9 give block A correction level.
// - Status bit 8 shows stereo; also routed to general pin three.
// - Status bits 7:0 give signal strength in dB steps, capped at 75.
package tosr_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_TEST_CFG = 6'h07;
    localparam logic [5:0] IDX_RSV_TEST = 6'h08;
    localparam logic [5:0] IDX_BOOT = 6'h09;
    localparam logic [5:0] IDX_STATUS = 6'h0a;
    localparam logic [5:0] IDX_CTRL = 6'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int XTAL_BIT = 15;
    localparam int HIZ_BIT = 14;
    localparam int ST_GRP = 15;
    localparam int ST_DONE = 14;
    localparam int ST_FAIL = 13;
    localparam int ST_RAIL = 12;
    localparam int ST_SYNC = 11;
    localparam int ST_STEREO = 8;
    localparam int CTRL_PWR = 0;
    localparam int CTRL_SEEK = 1;
    localparam int CTRL_TUNE = 2;
    localparam int CTRL_WRAP = 3;
    localparam int CTRL_VERB = 4;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [15:0] TEST_CFG_RST = 16'h0100;
    localparam logic [15:0] RSV_TEST_RST = 16'h0000;
    localparam logic [15:0] BOOT_RST = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'h001f;
    localparam logic [7:0] RSSI_MAX = 8'h4b;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Bus channel states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TOSR_WR_IDLE = 2'h1,
        TOSR_WR_RESP = 2'h2
    } tosr_wr_t;

    typedef enum logic [1:0] {
        TOSR_RD_IDLE = 2'h1,
        TOSR_RD_RESP = 2'h2
    } tosr_rd_t;

endpackage

/* logic/tosr_flag_if.sv */
`timescale 1ns/10ps
interface tosr_flag_if;
    // Control from the register side
    logic seekReq;
    logic tuneReq;
    logic seekWrap;
    logic rdsVerbose;
    logic statusRead;
    // Raw tuner core indications
    logic groupReady;
    logic seekDone;
    logic tuneDone;
    logic noChannel;
    logic bandEdge;
    logic afcRailed;
    logic rdsSynced;
    logic [1:0] blockAErr;
    logic stereo;
    logic [7:0] rssi;
    // Assembled status word
    logic [15:0] statusWord;

    modport regs (
        output seekReq, tuneReq, seekWrap, rdsVerbose, statusRead,
        output groupReady, seekDone, tuneDone, noChannel, bandEdge,
        output afcRailed, rdsSynced, blockAErr, stereo, rssi,
        input statusWord
    );
    modport flags (
        input seekReq, tuneReq, seekWrap, rdsVerbose, statusRead,
        input groupReady, seekDone, tuneDone, noChannel, bandEdge,
        input afcRailed, rdsSynced, blockAErr, stereo, rssi,
        output statusWord
    );
endinterface

/* logic/tosr_status_flags.sv */
`timescale 1ns/10ps
module tosr_status_flags (
    input wire logic clk,
    input wire logic nrst,
    tosr_flag_if.flags fl
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic grp;
        logic done;
        logic fail;
        logic rail;
        logic sync;
        logic [1:0] bler;
        logic stereo;
        logic [7:0] rssi;
        logic seekPrev;
        logic tunePrev;
    } tosr_flag_state_t;

    tosr_flag_state_t q_r;
    tosr_flag_state_t q_nxt;
    logic seekDrop;
    logic tuneDrop;

    // Falling edges of the host requests clear done, only the seek edge clears fail; grp clears on a status read
    assign seekDrop = q_r.seekPrev & ~fl.seekReq;
    assign tuneDrop = q_r.tunePrev & ~fl.tuneReq;

    // Sticky flags: a set in the clearing cycle wins
    always_comb begin
        q_nxt = q_r;
        q_nxt.seekPrev = fl.seekReq;
        q_nxt.tunePrev = fl.tuneReq;
        q_nxt.grp = fl.groupReady | (q_r.grp & ~fl.statusRead);
        q_nxt.done = fl.seekDone | fl.tuneDone
            | (q_r.done & ~(seekDrop | tuneDrop));
        q_nxt.fail = (fl.seekWrap ? fl.bandEdge : fl.noChannel)
            | (q_r.fail & ~seekDrop);
        // Tracked every cycle, so it is current at completion too
        q_nxt.rail = fl.afcRailed;
        q_nxt.sync = fl.rdsVerbose & fl.rdsSynced;
        q_nxt.bler = fl.rdsVerbose ? fl.blockAErr : 2'h0;
        q_nxt.stereo = fl.stereo;
        // Clamp rather than wrap: software scales against a fixed ceiling
        q_nxt.rssi = (fl.rssi > tosr_pkg::RSSI_MAX) ? tosr_pkg::RSSI_MAX : fl.rssi;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Word layout follows the field positions
    assign fl.statusWord = {q_r.grp, q_r.done, q_r.fail, q_r.rail, q_r.sync,
                            q_r.bler, q_r.stereo, q_r.rssi};

endmodule

/* logic/tosr_regs.sv */
`timescale 1ns/10ps
module tosr_regs (
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Tuner core indications
    input wire logic groupReady,
    input wire logic seekDone,
    input wire logic tuneDone,
    input wire logic noChannel,
    input wire logic bandEdge,
    input wire logic afcRailed,
    input wire logic rdsSynced,
    input wire logic [1:0] blockAErr,
    input wire logic stereo,
    input wire logic [7:0] rssi,
    input wire logic vioPresent,
    // Controls toward the tuner core and pins
    output logic xtalOscOn,
    output logic audioHizOn,
    output logic softMute,
    output logic generalPinThree,
    output logic powerUp,
    output logic seekReq,
    output logic tuneReq,
    output logic seekWrapMode,
    output logic rdsVerboseSel
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tosr_pkg::tosr_wr_t wst;
        tosr_pkg::tosr_rd_t rst;
        logic awHeld;
        logic wHeld;
        logic [5:0] wIdx;
        logic [15:0] wData;
        logic [1:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] testCfg;
        logic [15:0] rsvTest;
        logic [15:0] boot;
        logic [15:0] ctrl;
        logic statusRd;
        logic xtal;
        logic hiz;
        logic mute;
        logic pin3;
    } tosr_regs_state_t;

    tosr_regs_state_t q_r;
    tosr_regs_state_t q_nxt;
    tosr_flag_if fl ();

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Unmapped offsets answer with a slave error on both channels
    function automatic logic isMapped(input logic [5:0] idx);
        isMapped = (idx == tosr_pkg::IDX_TEST_CFG) || (idx == tosr_pkg::IDX_RSV_TEST)
                || (idx == tosr_pkg::IDX_BOOT) || (idx == tosr_pkg::IDX_STATUS)
                || (idx == tosr_pkg::IDX_CTRL);
    endfunction

    // Byte-lane merge for the 16-bit registers; upper lanes have no storage
    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [1:0] strb);
        mergeLanes = {strb[1] ? data[15:8] : old[15:8],
                      strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // ----------------------------------------------------------------
    // Status flag keeper
    // ----------------------------------------------------------------
    assign fl.seekReq = q_r.ctrl[tosr_pkg::CTRL_SEEK];
    assign fl.tuneReq = q_r.ctrl[tosr_pkg::CTRL_TUNE];
    assign fl.seekWrap = q_r.ctrl[tosr_pkg::CTRL_WRAP];
    assign fl.rdsVerbose = q_r.ctrl[tosr_pkg::CTRL_VERB];
    assign fl.statusRead = q_r.statusRd;
    assign fl.groupReady = groupReady;
    assign fl.seekDone = seekDone;
    assign fl.tuneDone = tuneDone;
    assign fl.noChannel = noChannel;
    assign fl.bandEdge = bandEdge;
    assign fl.afcRailed = afcRailed;
    assign fl.rdsSynced = rdsSynced;
    assign fl.blockAErr = blockAErr;
    assign fl.stereo = stereo;
    assign fl.rssi = rssi;

    tosr_status_flags u_flags (
        .clk(clk),
        .nrst(nrst),
        .fl(fl.flags)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    // Bus channels, register writes and derived pin controls
    always_comb begin
        logic awTake;
        logic wTake;
        logic [5:0] rIdx;
        logic [15:0] rWord;
        awTake = 1'b0;
        wTake = 1'b0;
        rIdx = s_axi_araddr[7:2];
        rWord = 16'h0000;
        q_nxt = q_r;
        q_nxt.statusRd = 1'b0;

        // Write channel: address and data are taken in either order
        unique case (q_r.wst)
            tosr_pkg::TOSR_WR_IDLE: begin
                awTake = s_axi_awvalid & q_r.awready;
                wTake = s_axi_wvalid & q_r.wready;
                if (awTake) begin
                    q_nxt.awHeld = 1'b1;
                    q_nxt.wIdx = s_axi_awaddr[7:2];
                end
                if (wTake) begin
                    q_nxt.wHeld = 1'b1;
                    q_nxt.wData = s_axi_wdata[15:0];
                    q_nxt.wStrb = s_axi_wstrb[1:0];
                end
                if (q_nxt.awHeld && q_nxt.wHeld) begin
                    q_nxt.bresp = isMapped(q_nxt.wIdx) ? tosr_pkg::RESP_OKAY
                                                       : tosr_pkg::RESP_SLVERR;
                    unique case (q_nxt.wIdx)
                        tosr_pkg::IDX_TEST_CFG: begin
                            q_nxt.testCfg = mergeLanes(q_r.testCfg, q_nxt.wData,
                                                       q_nxt.wStrb);
                        end
                        tosr_pkg::IDX_RSV_TEST: begin
                            q_nxt.rsvTest = mergeLanes(q_r.rsvTest, q_nxt.wData,
                                                       q_nxt.wStrb);
                        end
                        tosr_pkg::IDX_BOOT: begin
                            q_nxt.boot = mergeLanes(q_r.boot, q_nxt.wData, q_nxt.wStrb);
                        end
                        tosr_pkg::IDX_CTRL: begin
                            q_nxt.ctrl = mergeLanes(q_r.ctrl, q_nxt.wData, q_nxt.wStrb)
                                       & tosr_pkg::CTRL_MASK;
                        end
                        default: begin
                            // Status is read-only and other offsets have no storage
                            q_nxt.ctrl = q_r.ctrl;
                        end
                    endcase
                    q_nxt.awHeld = 1'b0;
                    q_nxt.wHeld = 1'b0;
                    q_nxt.bvalid = 1'b1;
                    q_nxt.awready = 1'b0;
                    q_nxt.wready = 1'b0;
                    q_nxt.wst = tosr_pkg::TOSR_WR_RESP;
                end else begin
                    q_nxt.awready = ~q_nxt.awHeld;
                    q_nxt.wready = ~q_nxt.wHeld;
                end
            end
            tosr_pkg::TOSR_WR_RESP: begin
                // Only one write in flight: both readies stay low here
                if (s_axi_bready) begin
                    q_nxt.bvalid = 1'b0;
                    q_nxt.awready = 1'b1;
                    q_nxt.wready = 1'b1;
                    q_nxt.wst = tosr_pkg::TOSR_WR_IDLE;
                end
            end
            default: begin
                q_nxt.wst = tosr_pkg::TOSR_WR_IDLE;
                q_nxt.awready = 1'b1;
                q_nxt.wready = 1'b1;
                q_nxt.bvalid = 1'b0;
            end
        endcase

        // Read channel: data is captured when the address is taken
        unique case (q_r.rst)
            tosr_pkg::TOSR_RD_IDLE: begin
                if (s_axi_arvalid && q_r.arready) begin
                    unique case (rIdx)
                        tosr_pkg::IDX_TEST_CFG: rWord = q_r.testCfg;
                        tosr_pkg::IDX_RSV_TEST: rWord = q_r.rsvTest;
                        tosr_pkg::IDX_BOOT: rWord = q_r.boot;
                        tosr_pkg::IDX_STATUS: rWord = fl.statusWord;
                        tosr_pkg::IDX_CTRL: rWord = q_r.ctrl;
                        default: rWord = 16'h0000;
                    endcase
                    q_nxt.rdata = {16'h0000, rWord};
                    q_nxt.rresp = isMapped(rIdx) ? tosr_pkg::RESP_OKAY
                                                 : tosr_pkg::RESP_SLVERR;
                    // Reading the status word retires the group-ready flag
                    q_nxt.statusRd = (rIdx == tosr_pkg::IDX_STATUS);
                    q_nxt.rvalid = 1'b1;
                    q_nxt.arready = 1'b0;
                    q_nxt.rst = tosr_pkg::TOSR_RD_RESP;
                end
            end
            tosr_pkg::TOSR_RD_RESP: begin
                if (s_axi_rready) begin
                    q_nxt.rvalid = 1'b0;
                    q_nxt.arready = 1'b1;
                    q_nxt.rst = tosr_pkg::TOSR_RD_IDLE;
                end
            end
            default: begin
                q_nxt.rst = tosr_pkg::TOSR_RD_IDLE;
                q_nxt.arready = 1'b1;
                q_nxt.rvalid = 1'b0;
            end
        endcase

        // Pin controls, registered so every output leaves a flop
        q_nxt.xtal = q_r.testCfg[tosr_pkg::XTAL_BIT];
        // Powered-up state overrides the bias request entirely
        q_nxt.hiz = q_r.testCfg[tosr_pkg::HIZ_BIT]
                  & ~q_r.ctrl[tosr_pkg::CTRL_PWR] & vioPresent;
        q_nxt.mute = fl.statusWord[tosr_pkg::ST_RAIL];
        q_nxt.pin3 = fl.statusWord[tosr_pkg::ST_STEREO];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '0;
            q_r.wst <= tosr_pkg::TOSR_WR_IDLE;
            q_r.rst <= tosr_pkg::TOSR_RD_IDLE;
            q_r.awready <= 1'b1;
            q_r.wready <= 1'b1;
            q_r.arready <= 1'b1;
            q_r.testCfg <= tosr_pkg::TEST_CFG_RST;
            q_r.rsvTest <= tosr_pkg::RSV_TEST_RST;
            q_r.boot <= tosr_pkg::BOOT_RST;
            q_r.ctrl <= tosr_pkg::CTRL_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rvalid = q_r.rvalid;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;
    assign xtalOscOn = q_r.xtal;
    assign audioHizOn = q_r.hiz;
    assign softMute = q_r.mute;
    assign generalPinThree = q_r.pin3;
    assign powerUp = q_r.ctrl[tosr_pkg::CTRL_PWR];
    assign seekReq = q_r.ctrl[tosr_pkg::CTRL_SEEK];
    assign tuneReq = q_r.ctrl[tosr_pkg::CTRL_TUNE];
    assign seekWrapMode = q_r.ctrl[tosr_pkg::CTRL_WRAP];
    assign rdsVerboseSel = q_r.ctrl[tosr_pkg::CTRL_VERB];

endmodule

/* sim/tosr_regs_sva.sv */
`timescale 1ns/10ps
module tosr_regs_chk (
    input logic clk,
    input logic nrst,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic afcRailed,
    input logic stereo,
    input logic vioPresent,
    input logic xtalOscOn,
    input logic audioHizOn,
    input logic softMute,
    input logic generalPinThree,
    input logic powerUp,
    input logic rdsVerboseSel
);
    // ------------------------------------------
    // Bus steps and status word checks
    // ------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Address and data taken at one edge
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_stat;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h28;
    endsequence

    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_UNMAPPED: assert property (wr_both ##0 s_axi_awaddr == 8'h30
        |=> s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("unmapped write not refused");
    AST_XTAL: assert property (
        wr_both ##0 (s_axi_awaddr == 8'h1c && s_axi_wstrb[1])
        |-> ##2 xtalOscOn == $past(s_axi_wdata[15], 2))
        else $error("oscillator enable does not follow write");
    AST_HIZ_OFF: assert property (powerUp || !vioPresent |=> !audioHizOn)
        else $error("audio high-z active while powered up or unsupplied");
    // Guarded so values from inside reset never reach the comparison
    AST_MUTE: assert property ($past(nrst) && $past(nrst, 2)
        |-> softMute == $past(afcRailed, 2))
        else $error("softmute does not track rail");
    AST_PIN3: assert property ($past(nrst) && $past(nrst, 2)
        |-> generalPinThree == $past(stereo, 2))
        else $error("general pin does not track stereo");
    AST_RSSI: assert property (rd_stat
        |=> s_axi_rvalid && s_axi_rdata[7:0] <= 8'h4b && s_axi_rdata[31:16] == 16'h0)
        else $error("status read out of range");
    AST_QUIET: assert property (
        rd_stat ##0 (!rdsVerboseSel && !$past(rdsVerboseSel))
        |=> s_axi_rdata[11:9] == 3'h0)
        else $error("sync or block A field nonzero outside verbose");
endmodule

bind tosr_regs tosr_regs_chk chk (.clk, .nrst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .afcRailed, .stereo, .vioPresent,
    .xtalOscOn, .audioHizOn, .softMute, .generalPinThree, .powerUp, .rdsVerboseSel);

/* sim/tosr_core_model.sv */
`timescale 1ns/10ps
module tosr_core_model (
    input logic clk,
    input logic nrst,
    input logic seekReq,
    input logic tuneReq,
    input logic failSeek,
    input logic edgeHit,
    input logic [3:0] lat,
    output logic seekDone,
    output logic tuneDone,
    output logic noChannel,
    output logic bandEdge
);
    logic [4:0] cnt;
    logic prevSeek, prevTune, isSeek;

    // Request rise starts a search lasting lat+1 cycles, then one-cycle pulses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {cnt, prevSeek, prevTune, isSeek} <= '0;
            {seekDone, tuneDone, noChannel, bandEdge} <= 4'h0;
        end else begin
            prevSeek <= seekReq;
            prevTune <= tuneReq;
            {seekDone, tuneDone, noChannel, bandEdge} <= 4'h0;
            if ((seekReq && !prevSeek) || (tuneReq && !prevTune)) begin
                cnt <= {1'b0, lat} + 5'h1;
                isSeek <= seekReq;
            end else if (cnt == 5'h1) begin
                cnt <= 5'h0;
                seekDone <= isSeek;
                tuneDone <= !isSeek;
                // Both failure kinds offered; the block must pick by wrap mode
                noChannel <= isSeek && failSeek;
                bandEdge <= isSeek && edgeHit;
            end else if (cnt != 5'h0) begin
                cnt <= cnt - 5'h1;
            end
        end
    end
endmodule

/* sim/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rssi, e;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, blockAErr, r;
    logic groupReady, seekDone, tuneDone, noChannel, bandEdge, afcRailed, rdsSynced, stereo;
    logic vioPresent, xtalOscOn, audioHizOn, softMute, generalPinThree, powerUp, seekReq;
    logic tuneReq, seekWrapMode, rdsVerboseSel, failSeek, edgeHit;
    logic [3:0] lat;
    logic [15:0] cv [4] = '{16'h0002, 16'h000a, 16'h0002, 16'h0004};
    logic [15:0] ex [4] = '{16'h6000, 16'h6000, 16'h4000, 16'h4000};
    logic [3:0] fs = 4'h1, eh = 4'h6;
    int fails, comparisons, i, n;

    tosr_regs dut (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .groupReady, .seekDone, .tuneDone,
        .noChannel, .bandEdge, .afcRailed, .rdsSynced, .blockAErr, .stereo, .rssi,
        .vioPresent, .xtalOscOn, .audioHizOn, .softMute, .generalPinThree, .powerUp,
        .seekReq, .tuneReq, .seekWrapMode, .rdsVerboseSel);
    tosr_core_model core (.clk, .nrst, .seekReq, .tuneReq, .failSeek, .edgeHit, .lat,
        .seekDone, .tuneDone, .noChannel, .bandEdge);

    // ------------------------------------------
    // Clock and bus tasks
    // ------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Response ready raised with the request
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] re);
        int k;
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {16'h0, v};
        s_axi_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 40) begin
            fails++;
            complete_run();
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, re)
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 40) begin
            fails++;
            complete_run();
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] v, input logic [1:0] re);
        rd(a);
        `CHK(d, {16'h0, v})
        `CHK(r, re)
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, rssi, s_axi_wdata, blockAErr, lat} = '0;
        {groupReady, afcRailed, rdsSynced, stereo, failSeek, edgeHit} = '0;
        vioPresent = 1'b1;
        nrst = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'h1c, 16'h0100, 2'h0);
        rdc(8'h20, 16'h0000, 2'h0);
        rdc(8'h24, 16'h0000, 2'h0);
        wr(8'h24, d[15:0], 2'h0);
        rdc(8'h28, 16'h0000, 2'h0);
        `CHK(xtalOscOn, 1'b0)
        // Unmapped place refused, status word not writable
        wr(8'h30, 16'hffff, 2'h2);
        rdc(8'h30, 16'h0000, 2'h2);
        wr(8'h28, 16'hffff, 2'h0);
        rdc(8'h28, 16'h0000, 2'h0);
        @(posedge clk);
        groupReady <= 1'b1;
        @(posedge clk);
        groupReady <= 1'b0;
        rdc(8'h28, 16'h8000, 2'h0);
        rdc(8'h28, 16'h0000, 2'h0);
        // Oscillator first, then power-up; low bits kept at the powered-down value
        wr(8'h1c, 16'hc100, 2'h0);
        @(negedge clk);
        `CHK({xtalOscOn, audioHizOn}, 2'h3)
        wr(8'h40, 16'h0001, 2'h0);
        @(negedge clk);
        `CHK({powerUp, audioHizOn}, 2'h2)
        wr(8'h40, 16'h0000, 2'h0);
        vioPresent <= 1'b0;
        @(negedge clk);
        `CHK(audioHizOn, 1'b1)
        @(negedge clk);
        `CHK(audioHizOn, 1'b0)
        @(posedge clk);
        vioPresent <= 1'b1;
        wr(8'h1c, 16'h0100, 2'h0);
        @(negedge clk);
        `CHK({xtalOscOn, audioHizOn}, 2'h0)
        // Seek and tune with prompt and slow completion, both failure kinds
        for (i = 0; i < 4; i++) begin
            failSeek <= fs[i];
            edgeHit <= eh[i];
            lat <= 4'(i * 5);
            wr(8'h40, cv[i], 2'h0);
            `CHK({seekWrapMode, tuneReq, seekReq, powerUp}, cv[i][3:0])
            d = '0;
            for (n = 0; n < 30 && d[14] !== 1'b1; n++) rd(8'h28);
            `CHK(d[15:0], ex[i])
            rdc(8'h28, ex[i], 2'h0);
            wr(8'h40, 16'h0000, 2'h0);
            rdc(8'h28, 16'h0000, 2'h0);
        end
        // Verbose fields, every block A code, signal strength at the cap
        afcRailed <= 1'b1;
        stereo <= 1'b1;
        rdsSynced <= 1'b1;
        wr(8'h40, 16'h0010, 2'h0);
        for (i = 0; i < 4; i++) begin
            blockAErr <= i[1:0];
            rssi <= 8'h4a + 8'(i);
            e = (i < 2) ? 8'h4a + 8'(i) : 8'h4b;
            rdc(8'h28, {4'h1, 1'b1, i[1:0], 1'b1, e}, 2'h0);
        end
        @(negedge clk);
        `CHK({softMute, generalPinThree, rdsVerboseSel}, 3'h7)
        wr(8'h40, 16'h0000, 2'h0);
        afcRailed <= 1'b0;
        rdc(8'h28, 16'h014b, 2'h0);
        @(negedge clk);
        `CHK(softMute, 1'b0)
        complete_run();
    end
endmodule
